//--- common/vec_pkg.sv
// Purpose: Shared constants and types for the vectored interrupt controller.
// Assumes: 32 channels, 16 vectored slots, APB register access on pclk.
// Notes:   Offsets are byte addresses on a 12-bit APB address.
//
// How it works
// - Writing the vector address register retires the active slot in the priority logic.
// - A one written to enable-clear clears that channel's enable bit.
// - Soft-request clear clears only the bits written as one.
// - A clear acts once per write; clearing again needs no zero write in between.
// - Source flag clearing shows one edge later in raw, fast and normal status.
// - Any channel set may route to fast; fast status shows pending ones.
// - A select bit of zero makes the channel a normal request.
// - The enable register holds one bit per channel at its channel number.
// - Slot control holds channel index low and enable at bit 5; slot 0 highest.
// - The vector read returns the best pending enabled slot's handler address.
// - With only non-vectored requests pending the vector read returns the default.
// - The core branches to its fixed vector and loads the vector address.
// - Enable-clear removes a request even while the source flag stays high.
// - The core may take a request raised during its own disable write.
// - A vanished request read at the vector returns the default handler address.
package vec_pkg;

  localparam int         N_CH        = 32;
  localparam int         N_SLOT      = 16;
  localparam int         SLOT_W      = 4;
  localparam int         CH_W        = 5;
  localparam int         CTRL_W      = 6;
  localparam int         EV_W        = 3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_RAW      = 12'h000;
  localparam logic [11:0] OFS_FAST_ST  = 12'h004;
  localparam logic [11:0] OFS_NORM_ST  = 12'h008;
  localparam logic [11:0] OFS_SELECT   = 12'h00C;
  localparam logic [11:0] OFS_ENABLE   = 12'h010;
  localparam logic [11:0] OFS_EN_CLR   = 12'h014;
  localparam logic [11:0] OFS_SOFT     = 12'h018;
  localparam logic [11:0] OFS_SOFT_CLR = 12'h01C;
  localparam logic [11:0] OFS_VECT     = 12'h030;
  localparam logic [11:0] OFS_DEFAULT  = 12'h034;
  localparam logic [11:0] OFS_EV_STAT  = 12'h040;
  localparam logic [11:0] OFS_EV_MASK  = 12'h044;
  localparam logic [3:0]  PAGE_SLOT_ADDR = 4'h1;
  localparam logic [3:0]  PAGE_SLOT_CTRL = 4'h2;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int          SLOT_EN_BIT  = 5;
  localparam int          SLOT_CH_LSB  = 0;
  localparam int          EV_NORMAL    = 0;
  localparam int          EV_FAST      = 1;
  localparam int          EV_DEFAULT   = 2;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [31:0] RST_DEF_ADDR = 32'h0000_0000;
  localparam logic [5:0]  RST_CTRL     = 6'h00;
  localparam logic [15:0] RST_ACTIVE   = 16'h0000;
  localparam logic [2:0]  RST_EV       = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } vec_bus_st_t;

  // Index of lowest set bit; 16 when none is set
  function automatic logic [4:0] first_set16(input logic [15:0] v);
    logic [4:0] idx;
    idx = 5'h10;
    for (int i = N_SLOT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : first_set16

endpackage : vec_pkg

//--- core/vec_ctrl.sv
// Purpose: Vectored interrupt controller with APB register access.
// Assumes: Source flags are synchronous to pclk and level sensitive.
// Notes:   Every transfer takes two access cycles; prdata and pready are registered.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
module vec_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] src_flags,
  output logic             irq_req,
  output logic             fiq_req,
  output logic             irq_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    vec_pkg::vec_bus_st_t bus_st;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          fast_route_select;
    logic [31:0]          channel_enable_mask;
    logic [31:0]          channel_enable_clear;
    logic [31:0]          soft_request_bits;
    logic [31:0]          soft_request_clear;
    logic [31:0]          default_handler_address;
    logic [15:0][5:0]     slot_control;
    logic [15:0]          active;
    logic                 cap_hit;
    logic [3:0]           cap_slot;
    logic [31:0]          raw_request_status;
    logic [31:0]          fast_request_status;
    logic [31:0]          normal_request_status;
    logic                 irq_req;
    logic                 fiq_req;
    logic [2:0]           ev_stat;
    logic [2:0]           ev_mask;
    logic                 irq_out;
  } vec_state_t;

  vec_state_t  r_reg;
  vec_state_t  r_next;

  logic        best_hit;
  logic [3:0]  best_slot;
  logic [31:0] mem_rdata;
  logic        mem_we;
  logic [3:0]  mem_raddr;

  logic        setup;
  logic        finish;
  logic        is_slot_addr;
  logic        is_slot_ctrl;
  logic        is_vect;
  logic [3:0]  word_idx;
  logic [31:0] raw_now;
  logic [31:0] fast_now;
  logic [31:0] norm_now;
  logic [2:0]  ev_set;
  logic [2:0]  ev_clr;
  logic [4:0]  ack_idx;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  vec_prio u_prio (
    .norm_st   (r_reg.normal_request_status),
    .slot_ctrl (r_reg.slot_control),
    .active    (r_reg.active),
    .hit       (best_hit),
    .slot      (best_slot)
  );

  vec_slot_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .waddr   (word_idx),
    .wdata   (pwdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  assign setup        = psel && !penable && (r_reg.bus_st == vec_pkg::ST_IDLE);
  assign finish       = psel && penable && (r_reg.bus_st == vec_pkg::ST_DONE);
  assign word_idx     = paddr[5:2];
  assign is_slot_addr = (paddr[11:8] == vec_pkg::PAGE_SLOT_ADDR) && (paddr[7:6] == 2'b00)
                        && (paddr[1:0] == 2'b00);
  assign is_slot_ctrl = (paddr[11:8] == vec_pkg::PAGE_SLOT_CTRL) && (paddr[7:6] == 2'b00)
                        && (paddr[1:0] == 2'b00);
  assign is_vect      = (paddr == vec_pkg::OFS_VECT);
  assign mem_we       = finish && pwrite && is_slot_addr;
  // Vector reads fetch the winning slot so its address is ready next cycle
  assign mem_raddr    = (is_vect && !pwrite) ? best_slot : word_idx;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next   = r_reg;
    ev_set   = 3'h0;
    ev_clr   = 3'h0;
    ack_idx  = vec_pkg::first_set16(r_reg.active);

    // Status follows the sources every cycle, so a cleared flag drops on the next edge
    raw_now  = src_flags | r_reg.soft_request_bits;
    fast_now = raw_now & r_reg.channel_enable_mask & r_reg.fast_route_select;
    norm_now = raw_now & r_reg.channel_enable_mask & ~r_reg.fast_route_select;
    r_next.raw_request_status    = raw_now;
    r_next.fast_request_status   = fast_now;
    r_next.normal_request_status = norm_now;
    // Held as a level so a request raised during a core disable write still stands
    r_next.irq_req = |norm_now;
    r_next.fiq_req = |fast_now;
    ev_set[vec_pkg::EV_NORMAL] = r_next.irq_req && !r_reg.irq_req;
    ev_set[vec_pkg::EV_FAST]   = r_next.fiq_req && !r_reg.fiq_req;

    case (r_reg.bus_st)
      vec_pkg::ST_IDLE: begin
        r_next.pready = 1'b0;
        if (setup) begin
          r_next.bus_st   = vec_pkg::ST_WAIT;
          // Winner frozen at setup so data and side effect agree
          r_next.cap_hit  = best_hit;
          r_next.cap_slot = best_slot;
        end
      end
      vec_pkg::ST_WAIT: begin
        r_next.bus_st  = vec_pkg::ST_DONE;
        r_next.pready  = 1'b1;
        r_next.pslverr = 1'b0;
        r_next.prdata  = vec_pkg::RST_WORD;
        if (is_slot_addr) begin
          r_next.prdata = mem_rdata;
        end else if (is_slot_ctrl) begin
          r_next.prdata = {26'h0, r_reg.slot_control[word_idx]};
        end else begin
          case (paddr)
            vec_pkg::OFS_RAW:      r_next.prdata = r_reg.raw_request_status;
            vec_pkg::OFS_FAST_ST:  r_next.prdata = r_reg.fast_request_status;
            vec_pkg::OFS_NORM_ST:  r_next.prdata = r_reg.normal_request_status;
            vec_pkg::OFS_SELECT:   r_next.prdata = r_reg.fast_route_select;
            vec_pkg::OFS_ENABLE:   r_next.prdata = r_reg.channel_enable_mask;
            vec_pkg::OFS_EN_CLR:   r_next.prdata = r_reg.channel_enable_clear;
            vec_pkg::OFS_SOFT:     r_next.prdata = r_reg.soft_request_bits;
            vec_pkg::OFS_SOFT_CLR: r_next.prdata = r_reg.soft_request_clear;
            vec_pkg::OFS_VECT: begin
              // No eligible slot, or the request vanished: default handler
              r_next.prdata = r_reg.cap_hit ? mem_rdata
                                            : r_reg.default_handler_address;
            end
            vec_pkg::OFS_DEFAULT:  r_next.prdata = r_reg.default_handler_address;
            vec_pkg::OFS_EV_STAT:  r_next.prdata = {29'h0, r_reg.ev_stat};
            vec_pkg::OFS_EV_MASK:  r_next.prdata = {29'h0, r_reg.ev_mask};
            default: begin
              r_next.pslverr = 1'b1;
            end
          endcase
        end
      end
      vec_pkg::ST_DONE: begin
        if (finish) begin
          r_next.bus_st  = vec_pkg::ST_IDLE;
          r_next.pready  = 1'b0;
          r_next.pslverr = 1'b0;
          if (pwrite) begin
            if (is_slot_ctrl) begin
              r_next.slot_control[word_idx] = pwdata[vec_pkg::CTRL_W-1:0];
            end else begin
              case (paddr)
                vec_pkg::OFS_SELECT: begin
                  r_next.fast_route_select = pwdata;
                end
                vec_pkg::OFS_ENABLE: begin
                  r_next.channel_enable_mask = r_reg.channel_enable_mask | pwdata;
                end
                vec_pkg::OFS_EN_CLR: begin
                  // Acts on the write itself; the stored copy is readback only
                  r_next.channel_enable_clear = pwdata;
                  r_next.channel_enable_mask  = r_reg.channel_enable_mask & ~pwdata;
                end
                vec_pkg::OFS_SOFT: begin
                  r_next.soft_request_bits = r_reg.soft_request_bits | pwdata;
                end
                vec_pkg::OFS_SOFT_CLR: begin
                  r_next.soft_request_clear = pwdata;
                  r_next.soft_request_bits  = r_reg.soft_request_bits & ~pwdata;
                end
                vec_pkg::OFS_VECT: begin
                  // Retire the highest active level; a write with none active is harmless
                  if (ack_idx < 5'h10) begin
                    r_next.active[ack_idx[3:0]] = 1'b0;
                  end
                end
                vec_pkg::OFS_DEFAULT: begin
                  r_next.default_handler_address = pwdata;
                end
                vec_pkg::OFS_EV_STAT: begin
                  ev_clr = pwdata[vec_pkg::EV_W-1:0];
                end
                vec_pkg::OFS_EV_MASK: begin
                  r_next.ev_mask = pwdata[vec_pkg::EV_W-1:0];
                end
                default: begin
                end
              endcase
            end
          end else if (is_vect) begin
            if (r_reg.cap_hit) begin
              r_next.active[r_reg.cap_slot] = 1'b1;
            end else begin
              ev_set[vec_pkg::EV_DEFAULT] = 1'b1;
            end
          end
        end
      end
      default: begin
        r_next.bus_st = vec_pkg::ST_IDLE;
        r_next.pready = 1'b0;
      end
    endcase

    // Set wins over a clear landing in the same cycle
    r_next.ev_stat = (r_reg.ev_stat & ~ev_clr) | ev_set;
    r_next.irq_out = |(r_next.ev_stat & r_next.ev_mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.bus_st                  <= vec_pkg::ST_IDLE;
      r_reg.prdata                  <= vec_pkg::RST_WORD;
      r_reg.pready                  <= 1'b0;
      r_reg.pslverr                 <= 1'b0;
      r_reg.fast_route_select       <= vec_pkg::RST_WORD;
      r_reg.channel_enable_mask     <= vec_pkg::RST_WORD;
      r_reg.channel_enable_clear    <= vec_pkg::RST_WORD;
      r_reg.soft_request_bits       <= vec_pkg::RST_WORD;
      r_reg.soft_request_clear      <= vec_pkg::RST_WORD;
      r_reg.default_handler_address <= vec_pkg::RST_DEF_ADDR;
      r_reg.slot_control            <= {vec_pkg::N_SLOT{vec_pkg::RST_CTRL}};
      r_reg.active                  <= vec_pkg::RST_ACTIVE;
      r_reg.cap_hit                 <= 1'b0;
      r_reg.cap_slot                <= 4'h0;
      r_reg.raw_request_status      <= vec_pkg::RST_WORD;
      r_reg.fast_request_status     <= vec_pkg::RST_WORD;
      r_reg.normal_request_status   <= vec_pkg::RST_WORD;
      r_reg.irq_req                 <= 1'b0;
      r_reg.fiq_req                 <= 1'b0;
      r_reg.ev_stat                 <= vec_pkg::RST_EV;
      r_reg.ev_mask                 <= vec_pkg::RST_EV;
      r_reg.irq_out                 <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata  = r_reg.prdata;
  assign pready  = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign irq_req = r_reg.irq_req;
  assign fiq_req = r_reg.fiq_req;
  assign irq_out = r_reg.irq_out;

endmodule : vec_ctrl

//--- core/vec_prio.sv
// Purpose: Picks the highest-priority pending vectored slot.
// Assumes: Slot 0 is the highest priority.
// Notes:   Purely combinational; caller registers the result.
`timescale 1ns/10ps
module vec_prio (
  input  wire logic [31:0]      norm_st,
  input  wire logic [15:0][5:0] slot_ctrl,
  input  wire logic [15:0]      active,
  output logic                  hit,
  output logic      [3:0]       slot
);

  logic [4:0] level;
  logic [4:0] ch;

  always_comb begin
    level = vec_pkg::first_set16(active);
    hit   = 1'b0;
    slot  = 4'h0;
    ch    = 5'h00;
    // Descending scan: the lowest eligible index wins
    for (int i = vec_pkg::N_SLOT - 1; i >= 0; i--) begin
      ch = slot_ctrl[i][vec_pkg::SLOT_CH_LSB +: vec_pkg::CH_W];
      if (slot_ctrl[i][vec_pkg::SLOT_EN_BIT] && norm_st[ch]
          && (5'(i) < level)) begin
        hit  = 1'b1;
        slot = 4'(i);
      end
    end
  end

endmodule : vec_prio

//--- core/vec_slot_mem.sv
// Purpose: Handler address store for the vectored slots.
// Assumes: One write port and one read port, registered read data.
// Notes:   Read data follows the address presented one edge earlier.
`timescale 1ns/10ps
module vec_slot_mem (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        we,
  input  wire logic [3:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  raddr,
  output logic      [31:0] rdata
);

  typedef struct packed {
    logic [15:0][31:0] mem;
    logic [31:0]       rdata;
  } vec_mem_state_t;

  vec_mem_state_t r_reg;
  vec_mem_state_t r_next;

  always_comb begin
    r_next       = r_reg;
    r_next.rdata = r_reg.mem[raddr];
    if (we) begin
      r_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.rdata;

endmodule : vec_slot_mem

//--- verif/testbench.sv
// Purpose: Self-checking bench for the vectored interrupt controller.
// Assumes: Fixed two-cycle APB answer; levels follow sources one cycle late.
// Notes:   Reads queue their expected data; a monitor compares on completion.
`timescale 1ns/10ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq_req, fiq_req, irq_out, core_mask, saved_mask;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, src_flags, e, s, r;
  logic [7:0]  irq_taken, fiq_taken;
  logic [32:0] exp_q[$];
  int          fails, num_checks, cyc;

  vec_ctrl i_vec_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_flags(src_flags), .irq_req(irq_req), .fiq_req(fiq_req),
    .irq_out(irq_out));
  vec_core_model i_vec_core_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .fiq_req(fiq_req), .core_mask(core_mask), .irq_taken(irq_taken),
    .fiq_taken(fiq_taken), .saved_mask(saved_mask));

  always #2 pclk = ~pclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // For reads d is the expected {error, data}
  task automatic bus(input logic w, input logic [11:0] a, input logic [32:0] d);
    if (!w) exp_q.push_back(d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus

  // Status lags the flags by one edge; the vector winner is picked at setup
  task automatic src(input logic [31:0] v);
    src_flags <= v;
    repeat (4) @(posedge pclk);
  endtask : src

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      wrap_up();
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src_flags = 32'h0;
    core_mask = 1'b0;
    r = $urandom(32'h2667_1CFA);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, vec_pkg::OFS_ENABLE, 33'h0);
    bus(0, vec_pkg::OFS_DEFAULT, 33'h0);
    repeat (6) begin
      e = $urandom();
      s = $urandom();
      r = $urandom();
      bus(1, vec_pkg::OFS_EN_CLR, 33'h0_FFFF_FFFF);
      bus(1, vec_pkg::OFS_ENABLE, {1'b0, e});
      bus(1, vec_pkg::OFS_SELECT, {1'b0, r});
      src(s);
      bus(0, vec_pkg::OFS_ENABLE, {1'b0, e});
      bus(0, vec_pkg::OFS_RAW, {1'b0, s});
      bus(0, vec_pkg::OFS_FAST_ST, {1'b0, s & e & r});
      bus(0, vec_pkg::OFS_NORM_ST, {1'b0, s & e & ~r});
      chk(33'(irq_req), 33'(|(s & e & ~r)));
      chk(33'(fiq_req), 33'(|(s & e & r)));
    end
    src(32'h0);
    bus(0, vec_pkg::OFS_NORM_ST, 33'h0);
    bus(1, vec_pkg::OFS_EN_CLR, 33'h0_FFFF_FFFF);
    bus(1, vec_pkg::OFS_SELECT, 33'h0);
    bus(1, vec_pkg::OFS_SOFT, 33'h5);
    bus(1, vec_pkg::OFS_SOFT_CLR, 33'h1);
    bus(0, vec_pkg::OFS_SOFT, 33'h4);
    bus(1, vec_pkg::OFS_SOFT, 33'h1);
    bus(1, vec_pkg::OFS_SOFT_CLR, 33'h0);
    bus(0, vec_pkg::OFS_SOFT, 33'h5);
    bus(1, vec_pkg::OFS_SOFT_CLR, 33'h1);
    bus(0, vec_pkg::OFS_SOFT, 33'h4);
    bus(0, vec_pkg::OFS_RAW, 33'h4);
    bus(1, vec_pkg::OFS_SOFT_CLR, 33'h4);
    // Flag that cannot be cleared at its source
    bus(1, vec_pkg::OFS_ENABLE, 33'h1);
    src(32'h1);
    chk(33'(irq_req), 33'h1);
    bus(1, vec_pkg::OFS_EN_CLR, 33'h1);
    // Request level lags the cleared enable by one more edge
    @(posedge pclk);
    chk(33'(irq_req), 33'h0);
    bus(0, vec_pkg::OFS_ENABLE, 33'h0);
    bus(0, vec_pkg::OFS_RAW, 33'h1);
    src(32'h0);
    bus(1, vec_pkg::OFS_DEFAULT, 33'h0_DEF0_0000);
    bus(1, {vec_pkg::PAGE_SLOT_ADDR, 8'h00}, 33'h0_0000_A000);
    bus(1, {vec_pkg::PAGE_SLOT_ADDR, 8'h04}, 33'h0_0000_B000);
    bus(1, {vec_pkg::PAGE_SLOT_CTRL, 8'h00}, 33'h26);
    bus(1, {vec_pkg::PAGE_SLOT_CTRL, 8'h04}, 33'h2A);
    bus(0, {vec_pkg::PAGE_SLOT_CTRL, 8'h04}, 33'h2A);
    bus(1, vec_pkg::OFS_ENABLE, 33'h0_0000_06C0);
    bus(0, vec_pkg::OFS_ENABLE, 33'h0_0000_06C0);
    src(32'h0000_0400);
    bus(0, vec_pkg::OFS_VECT, 33'h0_0000_B000);
    src(32'h0000_0440);
    bus(0, vec_pkg::OFS_VECT, 33'h0_0000_A000);
    bus(1, vec_pkg::OFS_VECT, 33'h0);
    src(32'h0000_0400);
    bus(0, vec_pkg::OFS_VECT, 33'h0_DEF0_0000);
    bus(1, vec_pkg::OFS_VECT, 33'h0);
    bus(0, vec_pkg::OFS_VECT, 33'h0_0000_B000);
    bus(1, vec_pkg::OFS_VECT, 33'h0);
    src(32'h0000_0200);
    bus(0, vec_pkg::OFS_VECT, 33'h0_DEF0_0000);
    src(32'h0);
    bus(0, vec_pkg::OFS_VECT, 33'h0_DEF0_0000);
    chk(33'(irq_taken != 8'h00), 33'h1);
    chk(33'(fiq_taken != 8'h00), 33'h1);
    bus(1, vec_pkg::OFS_EV_MASK, 33'h0);
    bus(1, vec_pkg::OFS_EV_STAT, 33'h7);
    bus(0, vec_pkg::OFS_EV_STAT, 33'h0);
    // Core disables in the cycle the request rises: still taken
    src_flags <= 32'h0000_0200;
    @(posedge pclk);
    core_mask <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(33'(saved_mask), 33'h1);
    chk(33'(irq_out), 33'h0);
    bus(0, vec_pkg::OFS_EV_STAT, 33'h1);
    bus(1, vec_pkg::OFS_EV_MASK, 33'h1);
    chk(33'(irq_out), 33'h1);
    bus(1, vec_pkg::OFS_EV_STAT, 33'h1);
    chk(33'(irq_out), 33'h0);
    bus(0, 12'h020, 33'h1_0000_0000);
    bus(0, 12'h300, 33'h1_0000_0000);
    bus(1, vec_pkg::OFS_RAW, 33'h0_FFFF_FFFF);
    bus(0, vec_pkg::OFS_RAW, 33'h0_0000_0200);
    wrap_up();
  end
endmodule : testbench

bind vec_ctrl vec_chk i_vec_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_flags(src_flags), .irq_req(irq_req),
  .fiq_req(fiq_req), .irq_out(irq_out));

//--- verif/vec_chk.sv
// Purpose: Port-level assertions for the vectored interrupt controller.
// Assumes: Bench holds sources steady for several cycles before status reads.
// Notes:   Enable, route and soft bits are shadowed from completed writes.
`timescale 1ns/10ps
module vec_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] src_flags,
  input wire logic        irq_req,
  input wire logic        fiq_req,
  input wire logic        irq_out
);
  logic [31:0] en_reg, sel_reg, soft_reg, raw;
  logic        wr_done, rd_done, want_irq, want_fiq;
  assign wr_done  = psel && penable && pready && pwrite;
  assign rd_done  = psel && penable && pready && !pwrite;
  assign raw      = src_flags | soft_reg;
  assign want_irq = |(raw & en_reg & ~sel_reg);
  assign want_fiq = |(raw & en_reg & sel_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg   <= 32'h0000_0000;
      sel_reg  <= 32'h0000_0000;
      soft_reg <= 32'h0000_0000;
    end else if (wr_done) begin
      case (paddr)
        vec_pkg::OFS_ENABLE:   en_reg   <= en_reg | pwdata;
        vec_pkg::OFS_EN_CLR:   en_reg   <= en_reg & ~pwdata;
        vec_pkg::OFS_SELECT:   sel_reg  <= pwdata;
        vec_pkg::OFS_SOFT:     soft_reg <= soft_reg | pwdata;
        vec_pkg::OFS_SOFT_CLR: soft_reg <= soft_reg & ~pwdata;
        default: ;
      endcase
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_lat; psel && !penable |=> !pready ##1 pready; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("ready not in second access cycle");
  property p_rdy_once; pready |=> !pready; endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("ready held too long");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error answer not clean");
  property p_irq; $stable(want_irq) ##1 $stable(want_irq) |-> irq_req == want_irq; endproperty
  a_irq: assert property (p_irq) else $error("normal request wrong");
  property p_fiq; $stable(want_fiq) ##1 $stable(want_fiq) |-> fiq_req == want_fiq; endproperty
  a_fiq: assert property (p_fiq) else $error("fast request wrong");
  // Full clear must drop both requests even with flags high
  property p_enclr;
    wr_done && paddr == vec_pkg::OFS_EN_CLR && pwdata == 32'hFFFF_FFFF
      |-> ##2 !irq_req && !fiq_req;
  endproperty
  a_enclr: assert property (p_enclr) else $error("request kept after clear");
  property p_raw;
    rd_done && paddr == vec_pkg::OFS_RAW && $past(src_flags, 4) == src_flags |-> prdata == raw;
  endproperty
  a_raw: assert property (p_raw) else $error("raw status wrong");
  property p_norm;
    rd_done && paddr == vec_pkg::OFS_NORM_ST && $past(src_flags, 4) == src_flags
      |-> prdata == (raw & en_reg & ~sel_reg);
  endproperty
  a_norm: assert property (p_norm) else $error("normal status wrong");
  property p_fast;
    rd_done && paddr == vec_pkg::OFS_FAST_ST && $past(src_flags, 4) == src_flags
      |-> prdata == (raw & en_reg & sel_reg);
  endproperty
  a_fast: assert property (p_fast) else $error("fast status wrong");
  property p_en; rd_done && paddr == vec_pkg::OFS_ENABLE |-> prdata == en_reg; endproperty
  a_en: assert property (p_en) else $error("enable mask wrong");
  property p_soft; rd_done && paddr == vec_pkg::OFS_SOFT |-> prdata == soft_reg; endproperty
  a_soft: assert property (p_soft) else $error("soft bits wrong");
endmodule : vec_chk

//--- verif/vec_core_model.sv
// Purpose: Behavioural core side: latches normal and fast requests.
// Assumes: Requests are levels synchronous to pclk.
// Notes:   Vector fetch itself is done by the bench over the bus.
`timescale 1ns/10ps
module vec_core_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       irq_req,
  input wire logic       fiq_req,
  input wire logic       core_mask,
  output logic     [7:0] irq_taken,
  output logic     [7:0] fiq_taken,
  output logic           saved_mask
);
  logic irq_q, fiq_q, mask_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q      <= 1'b0;
      fiq_q      <= 1'b0;
      mask_q     <= 1'b0;
      irq_taken  <= 8'h00;
      fiq_taken  <= 8'h00;
      saved_mask <= 1'b0;
    end else begin
      irq_q  <= irq_req;
      fiq_q  <= fiq_req;
      mask_q <= core_mask;
      // Latched before the disable landed, so still taken; status saved as set
      if (irq_req && !irq_q && !mask_q) begin
        irq_taken  <= irq_taken + 8'h01;
        saved_mask <= core_mask;
      end
      if (fiq_req && !fiq_q) begin
        fiq_taken <= fiq_taken + 8'h01;
      end
    end
  end
endmodule : vec_core_model
